// File: src/pipe_pkg.sv
package pipe_pkg;
  // instruction fields
  localparam int OPC_LSB = 26;
  localparam int RS_LSB = 21;
  localparam int RT_LSB = 16;
  localparam int RD_LSB = 11;
  localparam int TGT_W = 26;
  // primary opcodes
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_J = 6'h02;
  localparam logic [5:0] OP_JAL = 6'h03;
  localparam logic [5:0] OP_BEQ = 6'h04;
  localparam logic [5:0] OP_BNE = 6'h05;
  localparam logic [5:0] OP_ADDI = 6'h08;
  localparam logic [5:0] OP_SLTI = 6'h0a;
  localparam logic [5:0] OP_ANDI = 6'h0c;
  localparam logic [5:0] OP_ORI = 6'h0d;
  localparam logic [5:0] OP_LUI = 6'h0f;
  localparam logic [5:0] OP_LB = 6'h20;
  localparam logic [5:0] OP_LH = 6'h21;
  localparam logic [5:0] OP_LWL = 6'h22;
  localparam logic [5:0] OP_LW = 6'h23;
  localparam logic [5:0] OP_LBU = 6'h24;
  localparam logic [5:0] OP_LHU = 6'h25;
  localparam logic [5:0] OP_LWR = 6'h26;
  localparam logic [5:0] OP_SB = 6'h28;
  localparam logic [5:0] OP_SH = 6'h29;
  localparam logic [5:0] OP_SW = 6'h2b;
  // function codes
  localparam logic [5:0] FN_JR = 6'h08;
  localparam logic [5:0] FN_MFHI = 6'h10;
  localparam logic [5:0] FN_MFLO = 6'h12;
  localparam logic [5:0] FN_MULT = 6'h18;
  localparam logic [5:0] FN_DIV = 6'h1a;
  localparam logic [5:0] FN_ADD = 6'h20;
  localparam logic [5:0] FN_SUB = 6'h22;
  localparam logic [5:0] FN_AND = 6'h24;
  localparam logic [5:0] FN_OR = 6'h25;
  localparam logic [5:0] FN_XOR = 6'h26;
  localparam logic [5:0] FN_SLT = 6'h2a;
  localparam logic [4:0] ZERO_REG = 5'h00;
  localparam logic [4:0] LINK_REG = 5'h1f;
  // reset values, mapping
  localparam logic [31:0] RESET_PC = 32'hbfc00000;
  localparam logic [31:0] EXC_VECTOR = 32'h80000080;
  localparam logic [31:0] PHYS_MASK = 32'h1fffffff;
  localparam logic [31:0] INSTR_STEP = 32'h00000004;
  // timing counts in cycles
  localparam logic [4:0] MULDIV_CYCLES = 5'h10;
  localparam int SYSCTL_LATENCY = 3;
  // exception codes
  localparam logic [1:0] EXC_NONE = 2'h0;
  localparam logic [1:0] EXC_ILLEGAL = 2'h1;
  localparam logic [1:0] EXC_ADDR_LOAD = 2'h2;
  localparam logic [1:0] EXC_ADDR_STORE = 2'h3;

  typedef enum logic [2:0] {FMT_R = 3'b001, FMT_I = 3'b010, FMT_J = 3'b100} fmt_t;
  typedef enum logic [1:0] {MD_IDLE = 2'b01, MD_BUSY = 2'b10} md_state_t;

  typedef struct packed {
    logic valid;
    logic in_delay;
    logic [1:0] exc;
    logic [31:0] pc;
    logic [31:0] instr;
  } fetch_t;

  typedef struct packed {
    logic valid;
    logic in_delay;
    logic [1:0] exc;
    logic [31:0] pc;
    logic [5:0] opcode;
    logic [5:0] funct;
    logic wen;
    logic [4:0] dest;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] imm;
  } ex_t;

  typedef struct packed {
    logic valid;
    logic in_delay;
    logic [1:0] exc;
    logic [31:0] pc;
    logic [5:0] opcode;
    logic wen;
    logic [4:0] dest;
    logic req;
    logic write;
    logic [31:0] addr;
    logic [3:0] lanes;
    logic [31:0] wdata;
    logic [31:0] result;
    logic [31:0] old_rt;
  } mem_t;

  typedef struct packed {
    logic valid;
    logic wen;
    logic is_load;
    logic [4:0] dest;
    logic [31:0] value;
  } wb_t;
endpackage

// File: src/byte_lanes.sv
`timescale 1ns/1ps
module byte_lanes (
  input wire logic [1:0] i_first,
  input wire logic [1:0] i_last,
  input wire logic i_big,
  output logic [3:0] o_lanes
);
  always_comb begin
    o_lanes = 4'h0;
    for (int k = 0; k < 4; k++) begin
      if (2'(k) >= i_first && 2'(k) <= i_last) begin
        if (i_big) begin
          o_lanes[2'(3 - k)] = 1'b1; // [RULE18] [RULE20]
        end else begin
          o_lanes[2'(k)] = 1'b1; // [RULE18] [RULE21]
        end
      end
    end
  end
endmodule

// File: src/pipeline_core.sv
// Contract
// RULE1 - five stages: fetch, decode, execute, memory, write-back
// RULE2 - fetch translates the pc and reads the instruction cache
// RULE3 - decode stage reads source operands from the register file
// RULE4 - only loads and stores reach the data cache, in the memory stage
// RULE5 - write-back writes the result to the destination register
// RULE6 - a new instruction may start every cycle, five in flight
// RULE7 - previous result is forwarded without a stall
// RULE8 - high/low reads wait for a running multiply or divide
// RULE9 - high/low hold 64-bit product or quotient and remainder
// RULE10 - load data unseen by the next instruction, seen by the second
// RULE11 - left/right load merges with the complementary load just before
// RULE12 - jump or branch takes effect after its delay slot
// RULE13 - delay slots never stall or flush the pipeline
// RULE14 - exception completes older and cancels younger instructions
// RULE15 - system control changes reach the interface after several cycles
// RULE16 - one aligned 32-bit word per instruction, three formats
// RULE17 - address is base register plus sign-extended 16-bit offset
// RULE18 - address names the lowest byte: msb if big, lsb if little
// RULE19 - reverse-endian bit flips user-mode load and store byte order
// RULE20 - big-endian 32-bit lane map
// RULE21 - little-endian lane map mirrors big-endian
// RULE22 - zero register reads zero and discards every write
// RULE23 - results bound for the zero register are never forwarded
`timescale 1ns/1ps
module pipeline_core (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic [31:0] o_imem_addr,
  input wire logic [31:0] i_imem_data,
  output logic o_dmem_req,
  output logic o_dmem_write,
  output logic [31:0] o_dmem_addr,
  output logic [31:0] o_dmem_wdata,
  output logic [3:0] o_byte_lane_enable,
  input wire logic [31:0] i_dmem_rdata,
  input wire logic i_kernel_big_endian,
  input wire logic i_user_mode,
  input wire logic i_reverse_endian_user,
  output logic o_exc_taken,
  output logic [1:0] o_exc_code,
  output logic [31:0] o_exc_pc,
  output logic o_exc_in_delay
);
  pipe_pkg::fetch_t id_q, next_id;
  pipe_pkg::ex_t ex_q, next_ex;
  pipe_pkg::mem_t mem_q, next_mem;
  pipe_pkg::wb_t wb_q, next_wb;
  logic [31:0] pc, next_pc, imem_addr, next_imem_addr;
  logic [31:0] regs [32];
  pipe_pkg::md_state_t md_state, next_md_state;
  logic [4:0] md_count, next_md_count;
  logic [31:0] muldiv_high_result, next_high, muldiv_low_result, next_low;
  logic [31:0] pend_high, next_pend_high, pend_low, next_pend_low;
  logic [pipe_pkg::SYSCTL_LATENCY-1:0] re_pipe, next_re_pipe;
  logic big_strap, next_big_strap, strap_done, next_strap_done;
  logic exc_taken, next_exc_taken, exc_in_delay, next_exc_in_delay;
  logic [1:0] exc_code, next_exc_code;
  logic [31:0] exc_pc, next_exc_pc;
  logic exc_now, stall, md_start;
  logic [31:0] ex_result, mem_value, ex_addr;
  logic [1:0] span_first, span_last;
  logic ex_big;
  logic [3:0] ex_lanes;

  function automatic logic [31:0] phys(input logic [31:0] va);
    return va & pipe_pkg::PHYS_MASK; // [RULE2]
  endfunction

  function automatic logic is_load(input logic [5:0] opc);
    return opc inside {pipe_pkg::OP_LB, pipe_pkg::OP_LH, pipe_pkg::OP_LWL, pipe_pkg::OP_LW,
                       pipe_pkg::OP_LBU, pipe_pkg::OP_LHU, pipe_pkg::OP_LWR};
  endfunction

  function automatic logic is_store(input logic [5:0] opc);
    return opc inside {pipe_pkg::OP_SB, pipe_pkg::OP_SH, pipe_pkg::OP_SW};
  endfunction

  function automatic logic [1:0] lowest_lane(input logic [3:0] m);
    lowest_lane = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (m[k]) lowest_lane = 2'(k);
    end
  endfunction

  function automatic logic [1:0] highest_lane(input logic [3:0] m);
    highest_lane = 2'h0;
    for (int k = 0; k < 4; k++) begin
      if (m[k]) highest_lane = 2'(k);
    end
  endfunction

  function automatic logic [31:0] lane_bytes(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  // bypass; a load in execute is skipped on purpose
  function automatic logic [31:0] operand(input logic [4:0] idx);
    if (idx == pipe_pkg::ZERO_REG) return 32'h0; // [RULE22] [RULE23]
    if (ex_q.valid && ex_q.wen && ex_q.dest == idx && !is_load(ex_q.opcode))
      return ex_result; // [RULE7] [RULE10]
    if (mem_q.valid && mem_q.wen && mem_q.dest == idx) return mem_value; // [RULE10]
    if (wb_q.valid && wb_q.wen && wb_q.dest == idx) return wb_q.value;
    return regs[idx]; // [RULE3]
  endfunction

  assign exc_now = mem_q.valid && mem_q.exc != pipe_pkg::EXC_NONE;

  // decode stage and fetch
  always_comb begin
    logic [31:0] ins, a, b, sext, pc4, target;
    logic [5:0] opc, fn;
    logic [4:0] rs, rt, rd;
    logic taken, illegal, md_read;
    pipe_pkg::fmt_t fmt;
    ins = id_q.instr;
    opc = ins[pipe_pkg::OPC_LSB +: 6];
    fn = ins[5:0];
    rs = ins[pipe_pkg::RS_LSB +: 5];
    rt = ins[pipe_pkg::RT_LSB +: 5];
    rd = ins[pipe_pkg::RD_LSB +: 5];
    a = operand(rs);
    b = operand(rt);
    sext = {{16{ins[15]}}, ins[15:0]};
    pc4 = id_q.pc + pipe_pkg::INSTR_STEP;
    target = pc4 + {sext[29:0], 2'b00};
    taken = 1'b0;
    illegal = 1'b0;
    // only three formats are decoded
    fmt = (opc == pipe_pkg::OP_SPECIAL) ? pipe_pkg::FMT_R :
          (opc == pipe_pkg::OP_J || opc == pipe_pkg::OP_JAL) ? pipe_pkg::FMT_J :
          pipe_pkg::FMT_I; // [RULE16]
    next_ex = '0;
    next_ex.in_delay = id_q.in_delay;
    next_ex.exc = id_q.exc;
    next_ex.pc = id_q.pc;
    next_ex.opcode = opc;
    next_ex.funct = fn;
    next_ex.opa = a;
    next_ex.opb = b;
    next_ex.imm = sext;
    unique case (fmt)
      pipe_pkg::FMT_R: begin
        next_ex.dest = rd;
        next_ex.wen = fn inside {pipe_pkg::FN_ADD, pipe_pkg::FN_SUB, pipe_pkg::FN_AND,
                                 pipe_pkg::FN_OR, pipe_pkg::FN_XOR, pipe_pkg::FN_SLT,
                                 pipe_pkg::FN_MFHI, pipe_pkg::FN_MFLO};
        illegal = !next_ex.wen && !(fn inside {pipe_pkg::FN_JR, pipe_pkg::FN_MULT,
                                               pipe_pkg::FN_DIV});
        if (fn == pipe_pkg::FN_JR) begin
          taken = 1'b1;
          target = a;
        end
      end
      pipe_pkg::FMT_J: begin
        taken = 1'b1;
        target = {pc4[31:28], ins[pipe_pkg::TGT_W-1:0], 2'b00};
        next_ex.wen = (opc == pipe_pkg::OP_JAL);
        next_ex.dest = pipe_pkg::LINK_REG;
        next_ex.imm = pc4 + pipe_pkg::INSTR_STEP; // return past the delay slot
      end
      pipe_pkg::FMT_I: begin
        next_ex.dest = rt;
        next_ex.wen = is_load(opc) || opc inside {pipe_pkg::OP_ADDI, pipe_pkg::OP_SLTI,
                      pipe_pkg::OP_ANDI, pipe_pkg::OP_ORI, pipe_pkg::OP_LUI};
        if (opc == pipe_pkg::OP_ANDI || opc == pipe_pkg::OP_ORI) next_ex.imm = {16'h0, ins[15:0]};
        if (opc == pipe_pkg::OP_LUI) next_ex.imm = {ins[15:0], 16'h0};
        if (opc == pipe_pkg::OP_BEQ) taken = (a == b);
        if (opc == pipe_pkg::OP_BNE) taken = (a != b);
        illegal = !next_ex.wen && !is_store(opc) &&
                  !(opc inside {pipe_pkg::OP_BEQ, pipe_pkg::OP_BNE});
      end
    endcase
    if (illegal && id_q.exc == pipe_pkg::EXC_NONE) next_ex.exc = pipe_pkg::EXC_ILLEGAL;
    md_read = (fmt == pipe_pkg::FMT_R) && (fn == pipe_pkg::FN_MFHI || fn == pipe_pkg::FN_MFLO);
    stall = id_q.valid && md_read && (md_state == pipe_pkg::MD_BUSY || md_start); // [RULE8]
    next_ex.valid = id_q.valid && !stall && !exc_now; // [RULE14]
    // the word in fetch is the delay slot and always runs
    next_id.valid = 1'b1; // [RULE6]
    next_id.pc = pc;
    next_id.instr = i_imem_data; // [RULE2]
    next_id.exc = (pc[1:0] != 2'b00) ? pipe_pkg::EXC_ADDR_LOAD : pipe_pkg::EXC_NONE; // [RULE16]
    next_id.in_delay = id_q.valid && (taken || fmt == pipe_pkg::FMT_J);
    next_pc = taken && id_q.valid ? target : pc + pipe_pkg::INSTR_STEP; // [RULE12] [RULE13]
    if (stall) begin
      next_id = id_q;
      next_pc = pc;
    end
    if (exc_now) begin
      next_id = '0; // [RULE14]
      next_pc = pipe_pkg::EXC_VECTOR;
    end
    next_imem_addr = phys(next_pc);
  end

  byte_lanes u_lanes (
    .i_first(span_first),
    .i_last(span_last),
    .i_big(ex_big),
    .o_lanes(ex_lanes)
  );

  // execute stage
  always_comb begin
    logic [1:0] low;
    ex_addr = ex_q.opa + ex_q.imm; // [RULE17]
    low = ex_addr[1:0];
    // user accesses flip order once the delayed bit is set
    ex_big = big_strap ^ (i_user_mode && re_pipe[pipe_pkg::SYSCTL_LATENCY-1]); // [RULE19]
    span_first = low;
    span_last = low;
    unique case (ex_q.opcode)
      pipe_pkg::OP_LH, pipe_pkg::OP_LHU, pipe_pkg::OP_SH: span_last = 2'(low + 2'h1);
      pipe_pkg::OP_LW, pipe_pkg::OP_SW: begin
        span_first = 2'h0;
        span_last = 2'h3;
      end
      pipe_pkg::OP_LWL: if (ex_big) span_last = 2'h3; else span_first = 2'h0;
      pipe_pkg::OP_LWR: if (ex_big) span_first = 2'h0; else span_last = 2'h3;
      default: ;
    endcase
    ex_result = 32'h0;
    unique case (ex_q.opcode)
      pipe_pkg::OP_SPECIAL: begin
        unique case (ex_q.funct)
          pipe_pkg::FN_ADD: ex_result = ex_q.opa + ex_q.opb;
          pipe_pkg::FN_SUB: ex_result = ex_q.opa - ex_q.opb;
          pipe_pkg::FN_AND: ex_result = ex_q.opa & ex_q.opb;
          pipe_pkg::FN_OR: ex_result = ex_q.opa | ex_q.opb;
          pipe_pkg::FN_XOR: ex_result = ex_q.opa ^ ex_q.opb;
          pipe_pkg::FN_SLT: ex_result = {31'h0, $signed(ex_q.opa) < $signed(ex_q.opb)};
          pipe_pkg::FN_MFHI: ex_result = muldiv_high_result;
          pipe_pkg::FN_MFLO: ex_result = muldiv_low_result;
          default: ex_result = 32'h0;
        endcase
      end
      pipe_pkg::OP_ADDI: ex_result = ex_addr;
      pipe_pkg::OP_SLTI: ex_result = {31'h0, $signed(ex_q.opa) < $signed(ex_q.imm)};
      pipe_pkg::OP_ANDI: ex_result = ex_q.opa & ex_q.imm;
      pipe_pkg::OP_ORI: ex_result = ex_q.opa | ex_q.imm;
      default: ex_result = ex_q.imm;
    endcase
    md_start = ex_q.valid && !exc_now && ex_q.exc == pipe_pkg::EXC_NONE &&
               ex_q.opcode == pipe_pkg::OP_SPECIAL &&
               (ex_q.funct == pipe_pkg::FN_MULT || ex_q.funct == pipe_pkg::FN_DIV);
    next_mem = '0;
    next_mem.valid = ex_q.valid && !exc_now; // [RULE14]
    next_mem.in_delay = ex_q.in_delay;
    next_mem.exc = ex_q.exc;
    next_mem.pc = ex_q.pc;
    next_mem.opcode = ex_q.opcode;
    next_mem.wen = ex_q.wen;
    next_mem.dest = ex_q.dest;
    next_mem.result = ex_result;
    next_mem.old_rt = ex_q.opb;
    next_mem.addr = phys(ex_addr);
    next_mem.lanes = ex_lanes;
    next_mem.wdata = ex_q.opb << {lowest_lane(ex_lanes), 3'b000};
    if (ex_q.exc == pipe_pkg::EXC_NONE) begin
      if ((ex_q.opcode inside {pipe_pkg::OP_LH, pipe_pkg::OP_LHU} && low[0]) ||
          (ex_q.opcode == pipe_pkg::OP_LW && low != 2'h0))
        next_mem.exc = pipe_pkg::EXC_ADDR_LOAD;
      if ((ex_q.opcode == pipe_pkg::OP_SH && low[0]) ||
          (ex_q.opcode == pipe_pkg::OP_SW && low != 2'h0))
        next_mem.exc = pipe_pkg::EXC_ADDR_STORE;
    end
    next_mem.write = is_store(ex_q.opcode);
    next_mem.req = next_mem.valid && next_mem.exc == pipe_pkg::EXC_NONE &&
                   (is_load(ex_q.opcode) || next_mem.write); // [RULE4]
  end

  // memory stage and write-back selection
  always_comb begin
    logic [31:0] sr, old, bm;
    logic [1:0] lo_l, hi_l;
    lo_l = lowest_lane(mem_q.lanes);
    hi_l = highest_lane(mem_q.lanes);
    sr = i_dmem_rdata >> {lo_l, 3'b000};
    // partner load just ahead still sits in write-back
    old = (wb_q.valid && wb_q.wen && wb_q.is_load && wb_q.dest == mem_q.dest) ?
          wb_q.value : mem_q.old_rt; // [RULE11]
    bm = 32'h0;
    unique case (mem_q.opcode)
      pipe_pkg::OP_LB: mem_value = {{24{sr[7]}}, sr[7:0]};
      pipe_pkg::OP_LBU: mem_value = {24'h0, sr[7:0]};
      pipe_pkg::OP_LH: mem_value = {{16{sr[15]}}, sr[15:0]};
      pipe_pkg::OP_LHU: mem_value = {16'h0, sr[15:0]};
      pipe_pkg::OP_LW: mem_value = i_dmem_rdata;
      pipe_pkg::OP_LWL: begin
        bm = lane_bytes(mem_q.lanes) << {2'(2'h3 - hi_l), 3'b000};
        mem_value = ((i_dmem_rdata << {2'(2'h3 - hi_l), 3'b000}) & bm) | (old & ~bm); // [RULE11]
      end
      pipe_pkg::OP_LWR: begin
        bm = lane_bytes(mem_q.lanes) >> {lo_l, 3'b000};
        mem_value = (sr & bm) | (old & ~bm); // [RULE11]
      end
      default: mem_value = mem_q.result;
    endcase
    next_wb.valid = mem_q.valid && !exc_now; // [RULE14]
    next_wb.wen = mem_q.wen;
    next_wb.is_load = is_load(mem_q.opcode);
    next_wb.dest = mem_q.dest;
    next_wb.value = mem_value;
  end

  // multiply/divide unit; readers are held by the decode stall
  always_comb begin
    logic signed [63:0] prod;
    next_md_state = md_state;
    next_md_count = md_count;
    next_high = muldiv_high_result;
    next_low = muldiv_low_result;
    next_pend_high = pend_high;
    next_pend_low = pend_low;
    prod = $signed(ex_q.opa) * $signed(ex_q.opb);
    unique case (md_state)
      pipe_pkg::MD_IDLE: ;
      pipe_pkg::MD_BUSY: begin
        next_md_count = 5'(md_count - 5'h1);
        if (md_count == 5'h0) begin
          next_high = pend_high; // [RULE9]
          next_low = pend_low;
          next_md_state = pipe_pkg::MD_IDLE;
        end
      end
    endcase
    if (md_start) begin
      if (ex_q.funct == pipe_pkg::FN_MULT) begin
        next_pend_high = prod[63:32]; // [RULE9]
        next_pend_low = prod[31:0];
      end else if (ex_q.opb == 32'h0) begin
        next_pend_high = ex_q.opa;
        next_pend_low = 32'hffffffff;
      end else begin
        next_pend_high = 32'($signed(ex_q.opa) % $signed(ex_q.opb));
        next_pend_low = 32'($signed(ex_q.opa) / $signed(ex_q.opb));
      end
      next_md_count = 5'(pipe_pkg::MULDIV_CYCLES - 5'h1);
      next_md_state = pipe_pkg::MD_BUSY;
    end
  end

  // strap, delayed control bit, exception report
  always_comb begin
    next_strap_done = 1'b1;
    next_big_strap = strap_done ? big_strap : i_kernel_big_endian;
    next_re_pipe = {re_pipe[pipe_pkg::SYSCTL_LATENCY-2:0], i_reverse_endian_user}; // [RULE15]
    next_exc_taken = exc_now;
    next_exc_code = exc_now ? mem_q.exc : exc_code;
    next_exc_pc = exc_now ? mem_q.pc : exc_pc;
    next_exc_in_delay = exc_now ? mem_q.in_delay : exc_in_delay;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc <= pipe_pkg::RESET_PC;
      imem_addr <= pipe_pkg::RESET_PC & pipe_pkg::PHYS_MASK;
      id_q <= '0;
      ex_q <= '0;
      mem_q <= '0;
      wb_q <= '0;
      md_state <= pipe_pkg::MD_IDLE;
      md_count <= 5'h0;
      muldiv_high_result <= 32'h0;
      muldiv_low_result <= 32'h0;
      pend_high <= 32'h0;
      pend_low <= 32'h0;
      re_pipe <= '0;
      big_strap <= 1'b0;
      strap_done <= 1'b0;
      exc_taken <= 1'b0;
      exc_code <= pipe_pkg::EXC_NONE;
      exc_pc <= 32'h0;
      exc_in_delay <= 1'b0;
    end else begin
      pc <= next_pc;
      imem_addr <= next_imem_addr;
      id_q <= next_id; // [RULE1]
      ex_q <= next_ex;
      mem_q <= next_mem;
      wb_q <= next_wb;
      md_state <= next_md_state;
      md_count <= next_md_count;
      muldiv_high_result <= next_high;
      muldiv_low_result <= next_low;
      pend_high <= next_pend_high;
      pend_low <= next_pend_low;
      re_pipe <= next_re_pipe;
      big_strap <= next_big_strap;
      strap_done <= next_strap_done;
      exc_taken <= next_exc_taken;
      exc_code <= next_exc_code;
      exc_pc <= next_exc_pc;
      exc_in_delay <= next_exc_in_delay;
    end
  end

  // register file; entry zero is never written
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 32; i++) regs[i] <= 32'h0;
    end else if (wb_q.valid && wb_q.wen && wb_q.dest != pipe_pkg::ZERO_REG) begin
      regs[wb_q.dest] <= wb_q.value; // [RULE5] [RULE22]
    end
  end

  assign o_imem_addr = imem_addr;
  assign o_dmem_req = mem_q.req; // [RULE4]
  assign o_dmem_write = mem_q.write;
  assign o_dmem_addr = mem_q.addr;
  assign o_dmem_wdata = mem_q.wdata;
  assign o_byte_lane_enable = mem_q.lanes; // [RULE20] [RULE21]
  assign o_exc_taken = exc_taken;
  assign o_exc_code = exc_code;
  assign o_exc_pc = exc_pc;
  assign o_exc_in_delay = exc_in_delay;
endmodule

// File: tb/cache_model.sv
`timescale 1ns/1ps
module cache_model (
  input wire logic i_clk,
  input wire logic [31:0] i_imem_addr,
  output logic [31:0] o_imem_data,
  input wire logic i_dmem_req,
  input wire logic i_dmem_write,
  input wire logic [31:0] i_dmem_addr,
  input wire logic [31:0] i_dmem_wdata,
  input wire logic [3:0] i_byte_lane_enable,
  output logic [31:0] o_dmem_rdata
);
  logic [31:0] imem [64];
  logic [31:0] dmem [64];
  logic [67:0] st_log [$];
  logic [31:0] last = 32'h0;
  assign o_imem_data = imem[i_imem_addr[7:2]];
  // idle bus toggles: stale words never pass as load data
  assign o_dmem_rdata = (i_dmem_req && !i_dmem_write) ? dmem[i_dmem_addr[7:2]] : ~last;
  always @(posedge i_clk) begin
    last <= o_dmem_rdata;
    if (i_dmem_req === 1'b1 && i_dmem_write === 1'b1) begin
      for (int b = 0; b < 4; b++) begin
        if (i_byte_lane_enable[b]) begin
          dmem[i_dmem_addr[7:2]][8*b +: 8] <= i_dmem_wdata[8*b +: 8];
        end
      end
      st_log.push_back({i_dmem_addr, i_byte_lane_enable, i_dmem_wdata});
    end
  end
endmodule

// File: tb/pipeline_core_properties.sv
`timescale 1ns/1ps
module pipeline_core_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] o_imem_addr,
  input wire logic o_dmem_req,
  input wire logic [31:0] o_dmem_addr,
  input wire logic [3:0] o_byte_lane_enable,
  input wire logic o_exc_taken,
  input wire logic [1:0] o_exc_code,
  input wire logic [31:0] o_exc_pc
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_reset_fetch: assert property (disable iff (1'b0)
    !i_rst_n ##1 !i_rst_n |-> o_imem_addr == 32'h1fc00000 && !o_dmem_req)
    else $error("reset fetch");
  chk_fetch_phys: assert property (o_imem_addr[31:29] == 3'h0)
    else $error("untranslated fetch");
  chk_lane_first: assert property (o_dmem_req |->
    o_byte_lane_enable[2'h3 - o_dmem_addr[1:0]] || o_byte_lane_enable[o_dmem_addr[1:0]])
    else $error("lane missing");
  chk_lane_shape: assert property (o_dmem_req |-> o_byte_lane_enable inside
    {4'hf, 4'he, 4'h7, 4'hc, 4'h3, 4'h8, 4'h4, 4'h2, 4'h1}) else $error("bad lanes");
  chk_exc_pulse: assert property (o_exc_taken |=> !o_exc_taken)
    else $error("exception pulse too long");
  chk_exc_vector: assert property (o_exc_taken |-> o_exc_code != pipe_pkg::EXC_NONE &&
    o_imem_addr == (pipe_pkg::EXC_VECTOR & pipe_pkg::PHYS_MASK)) else $error("bad vector");
  chk_exc_no_req: assert property (o_exc_taken |-> !o_dmem_req)
    else $error("younger access kept");
  chk_exc_hold: assert property (!o_exc_taken |->
    $stable(o_exc_code) && $stable(o_exc_pc)) else $error("record changed");
endmodule
bind pipeline_core pipeline_core_properties u_props (.i_clk, .i_rst_n, .o_imem_addr,
  .o_dmem_req, .o_dmem_addr, .o_byte_lane_enable, .o_exc_taken, .o_exc_code, .o_exc_pc);

// File: tb/tb_pipeline_core.sv
`timescale 1ns/1ps
module tb_pipeline_core;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic big = 1'b1;
  logic user = 1'b0;
  logic rev = 1'b0;
  logic [31:0] ia, id, da, dw, dr, epc;
  logic dq, dwr, etk, edl;
  logic [3:0] ln;
  logic [1:0] ecd;
  logic [31:0] prog [$];
  int n_fail = 0;
  int check_count = 0;
  int n_exc = 0;
  always #10 i_clk = ~i_clk;
  pipeline_core u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_imem_addr(ia), .i_imem_data(id),
    .o_dmem_req(dq), .o_dmem_write(dwr), .o_dmem_addr(da), .o_dmem_wdata(dw),
    .o_byte_lane_enable(ln), .i_dmem_rdata(dr), .i_kernel_big_endian(big), .i_user_mode(user),
    .i_reverse_endian_user(rev), .o_exc_taken(etk), .o_exc_code(ecd), .o_exc_pc(epc),
    .o_exc_in_delay(edl));
  cache_model u_mem (.i_clk(i_clk), .i_imem_addr(ia), .o_imem_data(id), .i_dmem_req(dq),
    .i_dmem_write(dwr), .i_dmem_addr(da), .i_dmem_wdata(dw), .i_byte_lane_enable(ln),
    .o_dmem_rdata(dr));
  always @(posedge i_clk) begin
    if (etk === 1'b1) n_exc <= n_exc + 1;
  end
  function automatic logic [31:0] ii(logic [5:0] op, int rs, int rt, logic [15:0] im);
    return {op, rs[4:0], rt[4:0], im};
  endfunction
  function automatic logic [31:0] rr(int rs, int rt, int rd, logic [5:0] fn);
    return {pipe_pkg::OP_SPECIAL, rs[4:0], rt[4:0], rd[4:0], 5'h00, fn};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic st(input int i, input logic [31:0] a, input logic [3:0] l, input logic [31:0] d);
    logic [31:0] m;
    m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    chk("store addr", u_mem.st_log[i][67:36], a);
    chk("store lanes", 32'(u_mem.st_log[i][35:32]), 32'(l));
    chk("store data", u_mem.st_log[i][31:0] & m, d & m);
  endtask
  task automatic run(input int n, input int stores);
    @(negedge i_clk);
    i_rst_n = 1'b0;
    foreach (u_mem.imem[k]) u_mem.imem[k] = rr(0, 0, 0, pipe_pkg::FN_OR);
    foreach (prog[k]) u_mem.imem[k] = prog[k];
    u_mem.st_log.delete();
    n_exc = 0;
    repeat (20) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (n) @(negedge i_clk);
    chk("store count", u_mem.st_log.size(), stores);
  endtask
  task automatic t_fwd();
    prog = '{ii(pipe_pkg::OP_ORI, 0, 5, 16'h0010), ii(pipe_pkg::OP_ORI, 0, 1, 16'h0012),
      rr(1, 1, 2, pipe_pkg::FN_ADD), ii(pipe_pkg::OP_ORI, 0, 0, 16'h0005),
      rr(0, 0, 3, pipe_pkg::FN_ADD), ii(pipe_pkg::OP_SW, 5, 2, 16'hfffc),
      ii(pipe_pkg::OP_SW, 0, 3, 16'h0004)};
    run(20, 2);
    st(0, 32'hc, 4'hf, 32'h24);
    st(1, 32'h4, 4'hf, 32'h0);
  endtask
  task automatic t_branch();
    prog = '{ii(pipe_pkg::OP_BEQ, 0, 0, 16'h0002), ii(pipe_pkg::OP_ORI, 0, 4, 16'h0007),
      ii(pipe_pkg::OP_ORI, 0, 4, 16'h0009), ii(pipe_pkg::OP_SW, 0, 4, 16'h0000)};
    run(20, 1);
    st(0, 32'h0, 4'hf, 32'h7);
  endtask
  task automatic t_load();
    u_mem.dmem[0] = 32'h5a5a1234;
    u_mem.dmem[3] = 32'h00112233;
    u_mem.dmem[4] = 32'h44556677;
    prog = '{ii(pipe_pkg::OP_ORI, 0, 5, 16'h0077), ii(pipe_pkg::OP_LW, 0, 5, 16'h0000),
      rr(5, 0, 6, pipe_pkg::FN_ADD), rr(5, 0, 7, pipe_pkg::FN_ADD),
      ii(pipe_pkg::OP_SW, 0, 6, 16'h0004), ii(pipe_pkg::OP_SW, 0, 7, 16'h0008),
      ii(pipe_pkg::OP_LWL, 0, 8, 16'h000d), ii(pipe_pkg::OP_LWR, 0, 8, 16'h0010),
      rr(0, 0, 0, pipe_pkg::FN_OR), ii(pipe_pkg::OP_SW, 0, 8, 16'h0014)};
    run(20, 3);
    st(0, 32'h4, 4'hf, 32'h77);
    st(1, 32'h8, 4'hf, 32'h5a5a1234);
    st(2, 32'h14, 4'hf, 32'h11223344);
  endtask
  task automatic t_mul();
    prog = '{ii(pipe_pkg::OP_ORI, 0, 1, 16'h0006), ii(pipe_pkg::OP_LUI, 0, 2, 16'h8000),
      rr(1, 2, 0, pipe_pkg::FN_MULT), rr(0, 0, 3, pipe_pkg::FN_MFHI),
      rr(0, 0, 4, pipe_pkg::FN_MFLO), ii(pipe_pkg::OP_SW, 0, 3, 16'h0000),
      ii(pipe_pkg::OP_SW, 0, 4, 16'h0004)};
    run(50, 2);
    st(0, 32'h0, 4'hf, 32'hfffffffd);
    st(1, 32'h4, 4'hf, 32'h0);
  endtask
  task automatic t_lanes(input logic b, input logic u, input logic r);
    logic e;
    big = b;
    user = u;
    rev = r;
    e = b ^ (u & r);
    prog = '{ii(pipe_pkg::OP_ORI, 0, 1, 16'h00c3)};
    for (int k = 0; k < 4; k++) prog.push_back(ii(pipe_pkg::OP_SB, 0, 1, k[15:0]));
    prog.push_back(ii(pipe_pkg::OP_SH, 0, 1, 16'h0000));
    prog.push_back(ii(pipe_pkg::OP_SH, 0, 1, 16'h0002));
    prog.push_back(ii(pipe_pkg::OP_SW, 0, 1, 16'h0000));
    run(20, 7);
    for (int k = 0; k < 4; k++) begin
      st(k, k, e ? 4'h8 >> k : 4'h1 << k, {4{8'hc3}});
    end
    st(4, 32'h0, e ? 4'hc : 4'h3, 32'h00c300c3);
    st(5, 32'h2, e ? 4'h3 : 4'hc, 32'h00c300c3);
    st(6, 32'h0, 4'hf, 32'hc3);
  endtask
  task automatic t_exc();
    prog = '{ii(pipe_pkg::OP_ORI, 0, 1, 16'h0003), ii(pipe_pkg::OP_SW, 0, 1, 16'h0000),
      ii(pipe_pkg::OP_LW, 0, 2, 16'h0001), ii(pipe_pkg::OP_SW, 0, 1, 16'h0004),
      ii(pipe_pkg::OP_SW, 0, 1, 16'h0008)};
    run(20, 1);
    st(0, 32'h0, 4'hf, 32'h3);
    chk("exceptions", n_exc, 1);
    chk("exc code", 32'(ecd), 32'(pipe_pkg::EXC_ADDR_LOAD));
    chk("exc pc", epc, 32'hbfc00008);
    chk("exc delay", 32'(edl), 32'h0);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    t_fwd();
    t_branch();
    t_load();
    t_mul();
    t_lanes(1'b1, 1'b0, 1'b0);
    t_lanes(1'b0, 1'b0, 1'b0);
    t_lanes(1'b1, 1'b1, 1'b1);
    t_lanes(1'b0, 1'b1, 1'b1);
    t_exc();
    stop_test();
  end
endmodule
